//--- rtl/sdrc_defines.svh
// register map, field positions, reset values and timing constants
`ifndef SDRC_DEFINES_SVH
`define SDRC_DEFINES_SVH

// register byte offsets on the avalon slave
`define SDRC_OFF_CTRL     6'h00
`define SDRC_OFF_RATE     6'h04
`define SDRC_OFF_CHEN     6'h08
`define SDRC_OFF_STATUS   6'h0C
`define SDRC_OFF_DATA     6'h10
`define SDRC_OFF_ISTAT    6'h14
`define SDRC_OFF_IMASK    6'h18
// per-channel result window occupies 0x20..0x3C
`define SDRC_RES_BIT      5

// control register fields
`define SDRC_CTRL_RUN     0
`define SDRC_CTRL_ORDER   1
`define SDRC_CTRL_CHOP    2
`define SDRC_CTRL_NOTCH   3
`define SDRC_CTRL_APPEND  4
`define SDRC_CTRL_ZLAT    5
`define SDRC_CTRL_W       6

// interrupt status and mask fields
`define SDRC_IRQ_RESULT   0
`define SDRC_IRQ_PASS     1
`define SDRC_IRQ_W        2

// reset values
`define SDRC_CTRL_RST     6'h00
`define SDRC_RATE_RST     10'h060
`define SDRC_CHEN_RST     8'h01

// clocks: system clock and nominal master clock, in hertz
`define SDRC_SYS_HZ       25'd25000000
`define SDRC_MOD_HZ       25'd4920000

// master clock ticks per unit of the rate divider, minus one
`define SDRC_DEC_LAST     10'h3FF
// settling, in output periods
`define SDRC_SETTLE_O4    3'h4
`define SDRC_SETTLE_O3    3'h3
`define SDRC_SETTLE_CHOP  3'h2
// divider value that gives the 50 hz output rate
`define SDRC_NOTCH_DIV    10'h060

`endif

//--- rtl/sdrc_pkg.sv
// types shared by the rate and chop sequencer
package sdrc_pkg;
	// conversion engine states, gray along idle-reset-run
	typedef enum logic [1:0] {
		ENG_IDLE  = 2'b00,
		ENG_RESET = 2'b01,
		ENG_RUN   = 2'b11
	} sdrc_eng_t;

	// avalon access phases, gray along idle-fetch-done
	typedef enum logic [1:0] {
		BP_IDLE  = 2'b00,
		BP_FETCH = 2'b01,
		BP_DONE  = 2'b11
	} sdrc_bp_t;
endpackage : sdrc_pkg

//--- rtl/sdrc_mem_if.sv
// carrier between the sequencer and its result memory
`timescale 1ns/1ps
`default_nettype none
interface sdrc_mem_if #(
	parameter int AW = 3,
	parameter int DW = 24
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : sdrc_mem_if
`default_nettype wire

//--- rtl/sdrc_mem.sv
// per-channel last-result memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sdrc_mem #(
	parameter int AW = 3,
	parameter int DW = 24
) (
	input  wire logic  mclk_in,
	input  wire logic  nrst_in,
	input  wire logic  ce_in,
	sdrc_mem_if.mem    mem_port
);
	logic [DW-1:0] arr [0:(1<<AW)-1];
	logic [DW-1:0] rdata_reg;
	logic [DW-1:0] rdata_next;

	// array holds no reset; software reads only channels already written
	always_comb begin
		rdata_next = arr[mem_port.raddr];
	end

	always_ff @(posedge mclk_in) begin
		if (ce_in && mem_port.we) begin
			arr[mem_port.waddr] <= mem_port.wdata;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_reg <= '0;
		end else if (ce_in) begin
			rdata_reg <= rdata_next;
		end
	end

	assign mem_port.rdata = rdata_reg;
endmodule : sdrc_mem
`default_nettype wire

//--- rtl/sdrc_top.sv
// sigma-delta rate, chop and channel sequencer with avalon registers
//
// Contract
// - order bit 0 picks fourth-order filter (default), 1 picks third-order.
// - chop off: one result per channel every 1024 x divider master ticks.
// - chop off settling: four periods fourth-order, three third-order.
// - chop on: swap input polarity each settle, average successive results.
// - chop on: output period 1024 x divider times four or three.
// - chop on: settling is two output periods for either order.
// - divider at 50 hz and notch bit set adds 50 and 60 hz notches.
// - continuous mode steps through enabled channels only, one conversion each.
// - channel change resets modulator and filter, data-ready high, full settle.
// - data-ready low only with a valid result; next channel starts meanwhile.
// - one full pass takes settling time times enabled channel count.
// - all rates and settling derive from the 4.92 mhz master clock.
// - status byte low four bits carry the result's channel index.
// - data-ready returns high once a data register read completes.
// - zero-latency bit gives every conversion the full settling time.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_defines.svh"
module sdrc_top import sdrc_pkg::*; #(
	parameter int DATA_W = 24
) (
	input  wire logic              mclk_in,
	input  wire logic              nrst_in,
	input  wire logic              ce_in,
	input  wire logic [5:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	output var  logic [31:0]       avs_readdata_out,
	output var  logic              avs_waitrequest_out,
	input  wire logic [DATA_W-1:0] filt_data_in,
	output var  logic              irq_out,
	output var  logic              drdy_n_out,
	output var  logic              mod_reset_out,
	output var  logic              chop_pol_out,
	output var  logic              filter_order_out,
	output var  logic              dual_notch_out,
	output var  logic [2:0]        channel_sel_out
);
	// next enabled channel after cur, wrapping round the eight enables
	function automatic logic [2:0] next_chan(input logic [7:0] en,
		input logic [2:0] cur);
		logic [2:0] c;
		logic       found;
		c = cur;
		found = 1'b0;
		next_chan = cur;
		for (int i = 0; i < 8; i++) begin
			c = c + 3'h1;
			if (!found && en[c]) begin
				next_chan = c;
				found = 1'b1;
			end
		end
	endfunction : next_chan

	// status byte: data-ready in bit 7, channel index in the low nibble
	function automatic logic [7:0] stat_byte(input logic rdy_n,
		input logic [2:0] ch);
		stat_byte = {rdy_n, 4'h0, ch};
	endfunction : stat_byte

	sdrc_mem_if #(.AW(3), .DW(DATA_W)) mbus ();

	sdrc_mem #(.AW(3), .DW(DATA_W)) u_mem (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.ce_in    (ce_in),
		.mem_port (mbus.mem)
	);

	// bus and configuration state
	sdrc_bp_t                  bp_reg, bp_next;
	logic                      waitreq_reg, waitreq_next;
	logic [31:0]               rdata_reg, rdata_next;
	logic [`SDRC_CTRL_W-1:0]   ctrl_reg, ctrl_next;
	logic [9:0]                rate_reg, rate_next;
	logic [7:0]                chen_reg, chen_next;
	logic [`SDRC_IRQ_W-1:0]    istat_reg, istat_next;
	logic [`SDRC_IRQ_W-1:0]    imask_reg, imask_next;
	logic                      irq_reg, irq_next;
	logic                      notch_reg, notch_next;
	logic                      cfg_chg_reg, cfg_chg_next;
	logic [5:0]                adr;
	logic                      rd_done;
	logic                      wr_done;

	// engine state
	sdrc_eng_t                 eng_reg, eng_next;
	logic [24:0]               acc_reg, acc_next;
	logic [9:0]                dec_reg, dec_next;
	logic [9:0]                fsc_reg, fsc_next;
	logic [2:0]                stp_reg, stp_next;
	logic [2:0]                set_reg, set_next;
	logic [2:0]                chan_reg, chan_next;
	logic [2:0]                rch_reg, rch_next;
	logic                      pol_reg, pol_next;
	logic [DATA_W-1:0]         prev_reg, prev_next;
	logic [DATA_W-1:0]         data_reg, data_next;
	logic                      drdy_n_reg, drdy_n_next;
	logic                      modrst_reg, modrst_next;
	logic                      evres_reg, evres_next;
	logic                      evpass_reg, evpass_next;

	logic [24:0]               sum;
	logic                      tick;
	logic [9:0]                fs_eff;
	logic [2:0]                order_n;
	logic [2:0]                step_len;
	logic [2:0]                settle_len;
	logic                      base_p;
	logic                      step_p;
	logic                      multi;
	logic                      advance;
	logic [2:0]                nxt;
	logic [DATA_W:0]           diff;
	logic [DATA_W-1:0]         res;

	assign adr = {avs_address_in[5:2], 2'b00};
	assign rd_done = (bp_reg == BP_DONE) && avs_read_in
		&& (adr == `SDRC_OFF_DATA);
	assign wr_done = (bp_reg == BP_DONE) && avs_write_in;

	// bus slave: two wait states so memory reads land in a flop
	always_comb begin
		bp_next = bp_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		rate_next = rate_reg;
		chen_next = chen_reg;
		imask_next = imask_reg;
		cfg_chg_next = 1'b0;
		istat_next = istat_reg;
		case (bp_reg)
			BP_IDLE: begin
				if (avs_read_in || avs_write_in) begin
					bp_next = BP_FETCH;
				end
			end
			BP_FETCH: begin
				bp_next = BP_DONE;
				if (adr == `SDRC_OFF_CTRL) begin
					rdata_next = {26'h0, ctrl_reg};
				end else if (adr == `SDRC_OFF_RATE) begin
					rdata_next = {22'h0, rate_reg};
				end else if (adr == `SDRC_OFF_CHEN) begin
					rdata_next = {24'h0, chen_reg};
				end else if (adr == `SDRC_OFF_STATUS) begin
					rdata_next = {24'h0, stat_byte(drdy_n_reg, rch_reg)};
				end else if (adr == `SDRC_OFF_DATA) begin
					// status byte rides above the result when asked
					rdata_next = {ctrl_reg[`SDRC_CTRL_APPEND]
						? stat_byte(drdy_n_reg, rch_reg) : 8'h00, data_reg};
				end else if (adr == `SDRC_OFF_ISTAT) begin
					rdata_next = {30'h0, istat_reg};
				end else if (adr == `SDRC_OFF_IMASK) begin
					rdata_next = {30'h0, imask_reg};
				end else if (avs_address_in[`SDRC_RES_BIT]) begin
					rdata_next = {8'h00, mbus.rdata};
				end else begin
					rdata_next = 32'h0;
				end
			end
			default: begin
				bp_next = BP_IDLE;
			end
		endcase
		if (wr_done) begin
			if (adr == `SDRC_OFF_CTRL) begin
				ctrl_next = avs_writedata_in[`SDRC_CTRL_W-1:0];
				cfg_chg_next = 1'b1;
			end else if (adr == `SDRC_OFF_RATE) begin
				rate_next = avs_writedata_in[9:0];
				cfg_chg_next = 1'b1;
			end else if (adr == `SDRC_OFF_CHEN) begin
				chen_next = avs_writedata_in[7:0];
				cfg_chg_next = 1'b1;
			end else if (adr == `SDRC_OFF_ISTAT) begin
				istat_next = istat_reg & ~avs_writedata_in[1:0];
			end else if (adr == `SDRC_OFF_IMASK) begin
				imask_next = avs_writedata_in[1:0];
			end
		end
		// a new event beats a clear in the same cycle
		istat_next = istat_next | {evpass_reg, evres_reg};
		irq_next = |(istat_next & imask_next);
		notch_next = ctrl_next[`SDRC_CTRL_NOTCH]
			&& (rate_next == `SDRC_NOTCH_DIV);
		waitreq_next = (bp_next != BP_DONE);
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bp_reg <= BP_IDLE;
			waitreq_reg <= 1'b1;
			rdata_reg <= 32'h0;
			ctrl_reg <= `SDRC_CTRL_RST;
			rate_reg <= `SDRC_RATE_RST;
			chen_reg <= `SDRC_CHEN_RST;
			istat_reg <= '0;
			imask_reg <= '0;
			irq_reg <= 1'b0;
			notch_reg <= 1'b0;
			cfg_chg_reg <= 1'b0;
		end else if (ce_in) begin
			bp_reg <= bp_next;
			waitreq_reg <= waitreq_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			rate_reg <= rate_next;
			chen_reg <= chen_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			irq_reg <= irq_next;
			notch_reg <= notch_next;
			cfg_chg_reg <= cfg_chg_next;
		end
	end

	// timing terms shared by the engine
	always_comb begin
		sum = acc_reg + `SDRC_MOD_HZ;
		tick = (sum >= `SDRC_SYS_HZ);
		fs_eff = (rate_reg == 10'h000) ? 10'h001 : rate_reg;
		order_n = ctrl_reg[`SDRC_CTRL_ORDER]
			? `SDRC_SETTLE_O3 : `SDRC_SETTLE_O4;
		step_len = ctrl_reg[`SDRC_CTRL_CHOP] ? order_n : 3'h1;
		settle_len = ctrl_reg[`SDRC_CTRL_CHOP]
			? `SDRC_SETTLE_CHOP : order_n;
		base_p = tick && (dec_reg == `SDRC_DEC_LAST)
			&& (fsc_reg >= fs_eff - 10'h001);
		step_p = base_p && (stp_reg >= step_len - 3'h1);
		multi = |(chen_reg & (chen_reg - 8'h01));
		advance = multi || ctrl_reg[`SDRC_CTRL_ZLAT];
		nxt = next_chan(chen_reg, chan_reg);
		diff = pol_reg
			? {prev_reg[DATA_W-1], prev_reg} - {filt_data_in[DATA_W-1], filt_data_in}
			: {filt_data_in[DATA_W-1], filt_data_in} - {prev_reg[DATA_W-1], prev_reg};
		res = ctrl_reg[`SDRC_CTRL_CHOP] ? diff[DATA_W:1] : filt_data_in;
	end

	// conversion engine: master tick, divider, chop steps, sequencing
	always_comb begin
		eng_next = eng_reg;
		acc_next = acc_reg;
		dec_next = dec_reg;
		fsc_next = fsc_reg;
		stp_next = stp_reg;
		set_next = set_reg;
		chan_next = chan_reg;
		rch_next = rch_reg;
		pol_next = pol_reg;
		prev_next = prev_reg;
		data_next = data_reg;
		drdy_n_next = drdy_n_reg;
		modrst_next = 1'b0;
		evres_next = 1'b0;
		evpass_next = 1'b0;
		mbus.we = 1'b0;
		mbus.waddr = chan_reg;
		mbus.wdata = res;
		if (rd_done) begin
			drdy_n_next = 1'b1;
		end
		case (eng_reg)
			ENG_IDLE: begin
				modrst_next = 1'b1;
				if (ctrl_reg[`SDRC_CTRL_RUN] && (chen_reg != 8'h00)) begin
					eng_next = ENG_RESET;
				end
			end
			ENG_RESET: begin
				// hold modulator and filter in reset, data not ready
				modrst_next = 1'b1;
				drdy_n_next = 1'b1;
				acc_next = '0;
				dec_next = '0;
				fsc_next = '0;
				stp_next = '0;
				set_next = '0;
				pol_next = 1'b0;
				chan_next = next_chan(chen_reg, 3'h7);
				eng_next = ENG_RUN;
			end
			default: begin
				acc_next = tick ? sum - `SDRC_SYS_HZ : sum;
				if (tick) begin
					dec_next = dec_reg + 10'h001;
					if (dec_reg == `SDRC_DEC_LAST) begin
						fsc_next = base_p ? 10'h000 : fsc_reg + 10'h001;
					end
				end
				if (base_p) begin
					stp_next = step_p ? 3'h0 : stp_reg + 3'h1;
				end
				if (step_p) begin
					// swap the input pair after each settled phase
					pol_next = ctrl_reg[`SDRC_CTRL_CHOP] ? ~pol_reg : 1'b0;
					prev_next = filt_data_in;
					if (set_reg >= settle_len - 3'h1) begin
						// settled: publish, data-ready low only now
						data_next = res;
						rch_next = chan_reg;
						drdy_n_next = 1'b0;
						evres_next = 1'b1;
						mbus.we = 1'b1;
						if (advance) begin
							// restart the filter on the next channel
							chan_next = nxt;
							set_next = 3'h0;
							pol_next = 1'b0;
							modrst_next = 1'b1;
							evpass_next = (nxt <= chan_reg);
						end
					end else begin
						set_next = set_reg + 3'h1;
					end
				end
			end
		endcase
		// any control, rate or channel-enable write restarts the whole sequence
		if (cfg_chg_reg) begin
			eng_next = (ctrl_reg[`SDRC_CTRL_RUN] && (chen_reg != 8'h00))
				? ENG_RESET : ENG_IDLE;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			eng_reg <= ENG_IDLE;
			acc_reg <= '0;
			dec_reg <= '0;
			fsc_reg <= '0;
			stp_reg <= '0;
			set_reg <= '0;
			chan_reg <= '0;
			rch_reg <= '0;
			pol_reg <= 1'b0;
			prev_reg <= '0;
			data_reg <= '0;
			drdy_n_reg <= 1'b1;
			modrst_reg <= 1'b1;
			evres_reg <= 1'b0;
			evpass_reg <= 1'b0;
		end else if (ce_in) begin
			eng_reg <= eng_next;
			acc_reg <= acc_next;
			dec_reg <= dec_next;
			fsc_reg <= fsc_next;
			stp_reg <= stp_next;
			set_reg <= set_next;
			chan_reg <= chan_next;
			rch_reg <= rch_next;
			pol_reg <= pol_next;
			prev_reg <= prev_next;
			data_reg <= data_next;
			drdy_n_reg <= drdy_n_next;
			modrst_reg <= modrst_next;
			evres_reg <= evres_next;
			evpass_reg <= evpass_next;
		end
	end

	// memory read follows the bus address every cycle
	assign mbus.raddr = avs_address_in[4:2];

	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = waitreq_reg;
	assign irq_out = irq_reg;
	assign drdy_n_out = drdy_n_reg;
	assign mod_reset_out = modrst_reg;
	assign chop_pol_out = pol_reg;
	assign filter_order_out = ctrl_reg[`SDRC_CTRL_ORDER];
	assign dual_notch_out = notch_reg;
	assign channel_sel_out = chan_reg;
endmodule : sdrc_top
`default_nettype wire

//--- dv/sdrc_filt_model.sv
// stand-in for the decimation filter datapath feeding results
`timescale 1ns/1ps
`default_nettype none
module sdrc_filt_model (
	input  wire logic        mclk_in,
	input  wire logic        mod_reset_in,
	input  wire logic [2:0]  ch_in,
	input  wire logic        pol_in,
	output var  logic [23:0] data_out
);
	logic [23:0] val;
	// level tells the channel apart, so a mixed-up result shows
	assign val = {4'h1, 5'h00, ch_in, 12'h000};
	initial data_out = 24'h5A5A5A;
	// toggling junk while held in reset, never a stale level
	always @(posedge mclk_in) begin
		data_out <= mod_reset_in ? ~data_out : (pol_in ? -val : val);
	end
endmodule : sdrc_filt_model
`default_nettype wire

//--- dv/sdrc_chk_sva.sv
// assertions on the sequencer's bus and conversion ports
`timescale 1ns/1ps
`default_nettype none
module sdrc_chk (
	input wire logic        mclk_in,
	input wire logic        nrst_in,
	input wire logic [5:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        irq_out,
	input wire logic        drdy_n_out,
	input wire logic        mod_reset_out,
	input wire logic        chop_pol_out,
	input wire logic        filter_order_out,
	input wire logic [2:0]  channel_sel_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	logic        rd_done, wr_done, ord_reg, msk_reg;
	logic [15:0] age_reg;
	assign rd_done = avs_read_in && !avs_waitrequest_out;
	assign wr_done = avs_write_in && !avs_waitrequest_out;
	// shadows of order and mask; cycles since the filter left reset
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ord_reg <= 1'b0;
			msk_reg <= 1'b0;
			age_reg <= 16'h0000;
		end else begin
			if (wr_done && avs_address_in == 6'h00)
				ord_reg <= avs_writedata_in[1];
			if (wr_done && avs_address_in == 6'h18)
				msk_reg <= avs_writedata_in[0];
			age_reg <= mod_reset_out ? 16'h0000
				: age_reg + 16'(age_reg != 16'hFFFF);
		end
	end
	chk_bus_two_waits: assert property (($rose(avs_read_in) ||
		$rose(avs_write_in)) |-> avs_waitrequest_out ##1
		avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("access not answered after two wait cycles");
	chk_bus_single_ack: assert property (!avs_waitrequest_out |=>
		avs_waitrequest_out) else $error("waitrequest low too long");
	chk_bus_idle_wait: assert property (!avs_read_in && !avs_write_in &&
		avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest dropped without a request");
	chk_order_follows: assert property (
		wr_done && avs_address_in == 6'h00 |-> ##3
		filter_order_out == ord_reg) else $error("filter order wrong");
	chk_read_clears_rdy: assert property (
		rd_done && avs_address_in == 6'h10 |=> drdy_n_out)
		else $error("data read left data-ready low");
	chk_chan_reset: assert property (
		$changed(channel_sel_out) |-> (mod_reset_out ||
		$past(mod_reset_out)) or (##1 mod_reset_out))
		else $error("channel change without filter reset");
	chk_full_settle: assert property (
		$fell(drdy_n_out) |-> age_reg >= 16'd15400)
		else $error("result before the filter settled");
	chk_irq_follows: assert property (
		$fell(drdy_n_out) && msk_reg |-> ##[0:3] irq_out)
		else $error("unmasked result raised no interrupt");
	chk_hole_reads_zero: assert property (rd_done &&
		avs_address_in == 6'h1C |-> avs_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	cover property ($fell(drdy_n_out));
	cover property ($rose(irq_out));
	cover property ($rose(chop_pol_out));
endmodule : sdrc_chk
bind sdrc_top sdrc_chk u_chk (.mclk_in(mclk_in), .nrst_in(nrst_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_readdata_out(avs_readdata_out), .irq_out(irq_out),
	.avs_waitrequest_out(avs_waitrequest_out), .drdy_n_out(drdy_n_out),
	.mod_reset_out(mod_reset_out), .chop_pol_out(chop_pol_out),
	.filter_order_out(filter_order_out), .channel_sel_out(channel_sel_out));
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the rate and chop sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_defines.svh"
module testbench;
	logic        mclk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
	logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic [5:0]  avs_address_in = 6'h00;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
	logic        avs_waitrequest_out, irq_out, drdy_n_out, mod_reset_out;
	logic        chop_pol_out, filter_order_out, dual_notch_out;
	logic [2:0]  channel_sel_out;
	logic [23:0] filt_data_in;
	logic [31:0] seed = 32'hD6BA;
	int          bad_count = 0, samples_checked = 0, cyc = 0, t0, rate = 1;

	sdrc_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.filt_data_in(filt_data_in), .irq_out(irq_out),
		.drdy_n_out(drdy_n_out), .mod_reset_out(mod_reset_out),
		.chop_pol_out(chop_pol_out), .filter_order_out(filter_order_out),
		.dual_notch_out(dual_notch_out), .channel_sel_out(channel_sel_out));
	sdrc_filt_model u_filt (.mclk_in(mclk_in), .mod_reset_in(mod_reset_out),
		.ch_in(channel_sel_out), .pol_in(chop_pol_out),
		.data_out(filt_data_in));

	// clock and a free cycle count for period measurements
	always #20 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc <= cyc + 1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// cycles for n output periods at 25 mhz against a 4.92 mhz master
	function automatic int ec(input int n);
		return int'(longint'(n) * 1024 * rate * 25000000 / 4920000);
	endfunction : ec
	// accumulator phase is unknown, so allow a small window
	function automatic int near(input int g, input int e);
		return (g - e < 40 && e - g < 40) ? e : g;
	endfunction : near
	function automatic logic [23:0] fv(input int c);
		return 24'h100000 | (24'(c) << 12);
	endfunction : fv

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !w;
		avs_write_in <= w;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (n >= 20) begin
			bad_count++;
			tally_and_finish();
		end
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : bus
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc
	// waits for data-ready low, or for swapped polarity when pol is set
	task automatic wait_ev(input logic pol);
		int n;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while ((pol ? chop_pol_out : !drdy_n_out) !== 1'b1 && n < 60000);
		if (n >= 60000) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : wait_ev

	initial begin
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		chk(drdy_n_out, 1'b1);
		chk(mod_reset_out, 1'b1);
		rdc(`SDRC_OFF_CTRL, 32'h0);
		rdc(`SDRC_OFF_RATE, 32'h060);
		rdc(`SDRC_OFF_CHEN, 32'h01);
		rdc(6'h1C, 32'h0);
		bus(1'b1, `SDRC_OFF_CTRL, 32'h0A);
		repeat (3) @(posedge mclk_in);
		chk(filter_order_out, 1'b1);
		chk(dual_notch_out, 1'b1);
		bus(1'b1, `SDRC_OFF_RATE, 32'h1);
		bus(1'b1, `SDRC_OFF_CTRL, 32'h0);
		repeat (3) @(posedge mclk_in);
		chk(dual_notch_out, 1'b0);
		chk(filter_order_out, 1'b0);
		// random divider and mask values, divider kept legal
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			rate = int'(seed % 32'd1023) + 1;
			bus(1'b1, `SDRC_OFF_RATE, rate);
			rdc(`SDRC_OFF_RATE, rate);
			bus(1'b1, `SDRC_OFF_IMASK, seed);
			rdc(`SDRC_OFF_IMASK, seed & 32'h3);
		end
		$display("test registers done");
		// channels 0 and 2, third order, status byte appended
		rate = 1;
		bus(1'b1, `SDRC_OFF_RATE, 32'h1);
		bus(1'b1, `SDRC_OFF_IMASK, 32'h3);
		bus(1'b1, `SDRC_OFF_CHEN, 32'h05);
		bus(1'b1, `SDRC_OFF_CTRL, 32'h13);
		t0 = cyc;
		wait_ev(1'b0);
		chk(near(cyc - t0, ec(3)), ec(3));
		t0 = cyc;
		rdc(`SDRC_OFF_DATA, {8'h00, fv(0)});
		repeat (2) @(posedge mclk_in);
		chk(drdy_n_out, 1'b1);
		chk(irq_out, 1'b1);
		chk(channel_sel_out, 3'h2);
		wait_ev(1'b0);
		chk(near(cyc - t0, ec(3)), ec(3));
		rdc(`SDRC_OFF_DATA, {8'h02, fv(2)});
		repeat (2) @(posedge mclk_in);
		chk(channel_sel_out, 3'h0);
		// result window keeps each converted channel's last word
		rdc(6'h20, {8'h00, fv(0)});
		rdc(6'h28, {8'h00, fv(2)});
		bus(1'b1, `SDRC_OFF_IMASK, 32'h0);
		repeat (2) @(posedge mclk_in);
		chk(irq_out, 1'b0);
		rdc(`SDRC_OFF_ISTAT, 32'h3);
		bus(1'b1, `SDRC_OFF_ISTAT, 32'h3);
		rdc(`SDRC_OFF_ISTAT, 32'h0);
		bus(1'b1, `SDRC_OFF_IMASK, 32'h3);
		$display("test sequencer done");
		// single channel, fourth order, then steady rate
		bus(1'b1, `SDRC_OFF_CHEN, 32'h01);
		bus(1'b1, `SDRC_OFF_CTRL, 32'h01);
		t0 = cyc;
		wait_ev(1'b0);
		chk(near(cyc - t0, ec(4)), ec(4));
		t0 = cyc;
		rdc(`SDRC_OFF_DATA, {8'h00, fv(0)});
		// clock enable low: the period stretches by the frozen cycles
		ce_in <= 1'b0;
		repeat (100) @(posedge mclk_in);
		ce_in <= 1'b1;
		wait_ev(1'b0);
		chk(near(cyc - t0, ec(1) + 100), ec(1) + 100);
		chk(mod_reset_out, 1'b0);
		$display("test single channel done");
		// chop on, zero latency: swap after one step, result after two
		bus(1'b1, `SDRC_OFF_CTRL, 32'h27);
		t0 = cyc;
		wait_ev(1'b1);
		chk(near(cyc - t0, ec(3)), ec(3));
		wait_ev(1'b0);
		chk(near(cyc - t0, ec(6)), ec(6));
		chk(mod_reset_out, 1'b1);
		rdc(`SDRC_OFF_DATA, {8'h00, fv(0)});
		$display("test chop done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
